// ==== dcti_pkg.sv ====
// Constants and types shared by the torque interlock block
// Contract
// - Both channels on: output follows run command
// - Both channels off: inhibit output, safe mode
// - Latch select 0 latches, 1 not; default 0
// - Latched torque-off alarm held until reset command
// - Unlatched alarm clears when both channels return
// - After auto clear, run needs fresh edge
// - Restart select 1 runs held command after reset
// - Channel A alone off raises chan A error; code raises none while waiting to arm or in torque-off
// - Chan A error cleared only by power cycle
// - Channel B alone off raises chan B error; code raises none while waiting to arm or in torque-off
// - Chan B error cleared only by power cycle
// - Single channel and internal errors always latch
// - Codes 76 torque-off, 78 internal loop error
// - Codes 72 chan A error, 77 chan B
// - Fault history keeps six readable entries
// - Output inhibited within 20 ms of drop
// - Internal diagnostics fault raises internal loop error; code raises none once already halted
package dcti_pkg;

  localparam int unsigned CLK_FREQ_HZ    = 10_000_000;
  localparam int unsigned RESPONSE_MS    = 20;
  localparam int unsigned RESPONSE_CYC   = (CLK_FREQ_HZ / 1000) * RESPONSE_MS;
  localparam int unsigned SKEW_WINDOW_US = 100;
  localparam int unsigned SKEW_CYC       = (CLK_FREQ_HZ / 1_000_000) * SKEW_WINDOW_US;
  localparam int unsigned HIST_DEPTH     = 6;

  localparam logic [7:0] CODE_NONE  = 8'h00;
  localparam logic [7:0] CODE_CHANA = 8'h48;  // 72
  localparam logic [7:0] CODE_TORQ  = 8'h4c;  // 76
  localparam logic [7:0] CODE_CHANB = 8'h4d;  // 77
  localparam logic [7:0] CODE_INTL  = 8'h4e;  // 78

  localparam logic ALARM_LATCH_RESET = 1'b0;

  typedef enum logic [2:0] {
    DCTI_WAIT_ARM = 3'b000,
    DCTI_STANDBY  = 3'b001,
    DCTI_RUN      = 3'b010,
    DCTI_SKEW     = 3'b011,
    DCTI_TORQ_OFF = 3'b100,
    DCTI_HALT     = 3'b101
  } dcti_state_e;

endpackage : dcti_pkg

// ==== dcti_sync.sv ====
// Two-flop synchroniser for the channel inputs
`timescale 1ns/1ps
module dcti_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // A zero-width bundle has nothing to carry
  initial
  begin
    if (WIDTH < 1)
      $error("dcti_sync WIDTH out of range");
  end

  // Channels rest deasserted so output stays inhibited after reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : dcti_sync

// ==== dcti_hist_mem.sv ====
// Six-entry fault history memory with registered read port
`timescale 1ns/1ps
module dcti_hist_mem #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         push_code,
  input  wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic      [WIDTH-1:0]         rd_code
);
  logic [WIDTH-1:0] entry_reg [DEPTH];

  // Fewer than two entries would leave the read index with no bits
  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("dcti_hist_mem parameters out of range");
  end

  // Newest record at entry 0, oldest shifted out
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        entry_reg[i] <= '0;
    end
    else if (push)
    begin
      entry_reg[0] <= push_code;
      for (int i = 1; i < DEPTH; i++)
        entry_reg[i] <= entry_reg[i-1];
    end
  end

  // Registered read; out-of-range index reads zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_code <= '0;
    else if (int'(rd_index) < DEPTH)
      rd_code <= entry_reg[rd_index];
    else
      rd_code <= '0;
  end
endmodule : dcti_hist_mem

// ==== dcti_interlock.sv ====
// Dual channel torque interlock controller
`timescale 1ns/1ps
module dcti_interlock #(
  parameter int unsigned SKEW_CYCLES = dcti_pkg::SKEW_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       chan_a_enable_in,
  input  wire logic       chan_b_enable_in,
  input  wire logic       run_cmd,
  input  wire logic       reset_cmd,
  input  wire logic       alarm_latch_select,
  input  wire logic       restart_after_reset_select,
  input  wire logic       diag_fault,
  input  wire logic [2:0] fault_history_index,
  output logic            output_enable,
  output logic            torque_off_alarm,
  output logic            chan_a_loop_error,
  output logic            chan_b_loop_error,
  output logic            internal_loop_error,
  output logic      [7:0] fault_code,
  output logic      [7:0] fault_history_entry
);
  import dcti_pkg::*;

  // Skew window must fit well inside the response budget
  initial
  begin
    // Skew counter is 16 bits wide, so a longer window would wrap
    if (SKEW_CYCLES < 1 || SKEW_CYCLES >= RESPONSE_CYC || SKEW_CYCLES > 32'h0000_ffff)
      $error("SKEW_CYCLES out of range");
  end

  logic [1:0]  chan_sync;
  logic        a_ok;
  logic        b_ok;
  logic        both_ok;
  logic        both_off;
  logic        single_off;
  logic        reset_q_reg;
  logic        reset_rise;
  logic        diag_s1_reg;
  logic        diag_s2_reg;
  logic        need_new_run_reg;
  logic [15:0] skew_cnt_reg;
  logic        skew_done;
  logic        push;
  logic [7:0]  push_code;
  dcti_state_e state_reg;
  dcti_state_e state_next;

  // Channel inputs cross in from the switch
  dcti_sync #(
    .WIDTH    (2)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({chan_b_enable_in, chan_a_enable_in}),
    .sync_out (chan_sync)
  );

  assign a_ok       = chan_sync[0];
  assign b_ok       = chan_sync[1];
  assign both_ok    = a_ok & b_ok;
  assign both_off   = ~a_ok & ~b_ok;
  assign single_off = a_ok ^ b_ok;
  assign skew_done  = (skew_cnt_reg >= 16'(SKEW_CYCLES - 1));

  // Diagnostic fault is asynchronous to us, so synchronise it too
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      diag_s1_reg <= 1'b0;
      diag_s2_reg <= 1'b0;
    end
    else
    begin
      diag_s1_reg <= diag_fault;
      diag_s2_reg <= diag_s1_reg;
    end
  end

  // Edge detector for the reset command; run acts on its level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reset_q_reg <= 1'b0;
    end
    else
    begin
      reset_q_reg <= reset_cmd;
    end
  end

  assign reset_rise = reset_cmd & ~reset_q_reg;

  // Skew counter runs while one channel alone is down
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      skew_cnt_reg <= '0;
    else if (state_reg == DCTI_SKEW)
      skew_cnt_reg <= skew_cnt_reg + 16'h0001;
    else
      skew_cnt_reg <= '0;
  end

  // Main interlock sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      DCTI_WAIT_ARM:
        if (diag_s2_reg)
          state_next = DCTI_HALT;
        else if (both_ok)
          state_next = DCTI_STANDBY;
      DCTI_STANDBY, DCTI_RUN:
        if (diag_s2_reg)
          state_next = DCTI_HALT;
        else if (both_off)
          state_next = DCTI_TORQ_OFF;
        else if (single_off)
          state_next = DCTI_SKEW;
        else if (run_cmd && (state_reg == DCTI_RUN || !need_new_run_reg))
          state_next = DCTI_RUN;
        else
          state_next = DCTI_STANDBY;
      DCTI_SKEW:
        if (diag_s2_reg)
          state_next = DCTI_HALT;
        else if (both_off)
          state_next = DCTI_TORQ_OFF;
        else if (both_ok)
          state_next = DCTI_STANDBY;
        else if (skew_done)
          state_next = DCTI_HALT;
      DCTI_TORQ_OFF:
        if (diag_s2_reg)
          state_next = DCTI_HALT;
        else if (single_off)
          state_next = DCTI_TORQ_OFF;
        else if (both_ok && alarm_latch_select != ALARM_LATCH_RESET)
          state_next = DCTI_STANDBY;
        else if (both_ok && reset_rise)
          state_next = (restart_after_reset_select && run_cmd)
                       ? DCTI_RUN : DCTI_STANDBY;
      DCTI_HALT:
        state_next = DCTI_HALT;
      default:
        state_next = DCTI_WAIT_ARM;
    endcase
  end

  // State only leaves halt through power-on reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= DCTI_WAIT_ARM;
    else
      state_reg <= state_next;
  end

  // Fresh run edge needed after auto clear or non-restart reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      need_new_run_reg <= 1'b0;
    else if (state_reg == DCTI_TORQ_OFF && state_next == DCTI_STANDBY)
      need_new_run_reg <= 1'b1;
    else if (!run_cmd)
      need_new_run_reg <= 1'b0;
  end

  // Output gate: only running with both channels sampled on
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      output_enable <= 1'b0;
    else
      output_enable <= (state_next == DCTI_RUN) && both_ok;
  end

  // Alarm flags; single-channel ones ignore latch select
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      torque_off_alarm    <= 1'b0;
      chan_a_loop_error   <= 1'b0;
      chan_b_loop_error   <= 1'b0;
      internal_loop_error <= 1'b0;
    end
    else
    begin
      torque_off_alarm <= (state_next == DCTI_TORQ_OFF);
      if (state_reg != DCTI_HALT && state_next == DCTI_HALT)
      begin
        chan_a_loop_error   <= !diag_s2_reg && !a_ok;
        chan_b_loop_error   <= !diag_s2_reg && !b_ok;
        internal_loop_error <= diag_s2_reg;
      end
    end
  end

  // Record one code on each entry to a fault state
  always_comb
  begin
    push      = 1'b0;
    push_code = CODE_NONE;
    if (state_reg != DCTI_HALT && state_next == DCTI_HALT)
    begin
      push      = 1'b1;
      push_code = diag_s2_reg ? CODE_INTL : (!a_ok ? CODE_CHANA : CODE_CHANB);
    end
    else if (state_reg != DCTI_TORQ_OFF && state_next == DCTI_TORQ_OFF)
    begin
      push      = 1'b1;
      push_code = CODE_TORQ;
    end
  end

  // Current fault code, zero when clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fault_code <= CODE_NONE;
    else if (push)
      fault_code <= push_code;
    else if (state_next != DCTI_HALT && state_next != DCTI_TORQ_OFF)
      fault_code <= CODE_NONE;
  end

  // Fault history of six records
  dcti_hist_mem #(
    .DEPTH     (HIST_DEPTH),
    .WIDTH     (8)
  ) u_hist (
    .clk       (clk),
    .reset_n   (reset_n),
    .push      (push),
    .push_code (push_code),
    .rd_index  (fault_history_index),
    .rd_code   (fault_history_entry)
  );

  // Assertions
  property p_both_ok_run;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DCTI_RUN && both_ok && !diag_s2_reg && !run_cmd) |=> !output_enable;
  endproperty
  a_both_ok_run: assert property (p_both_ok_run) else $error("run drop ignored");

  property p_both_off_inhibit;
    @(posedge clk) disable iff (!reset_n)
    both_off |=> !output_enable && (torque_off_alarm || state_reg == DCTI_HALT
                                    || state_reg == DCTI_WAIT_ARM);
  endproperty
  a_both_off_inhibit: assert property (p_both_off_inhibit) else $error("no inhibit");

  property p_latch_hold;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DCTI_TORQ_OFF && !alarm_latch_select && !reset_rise && !diag_s2_reg)
    |=> torque_off_alarm;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched alarm fell");

  property p_auto_clear;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DCTI_TORQ_OFF && alarm_latch_select && both_ok && !diag_s2_reg)
    |=> !torque_off_alarm ##1 (state_reg == DCTI_STANDBY);
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("no auto clear");

  property p_no_restart_held;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DCTI_TORQ_OFF && state_next == DCTI_STANDBY) ##1 run_cmd [*2]
    |-> !output_enable;
  endproperty
  a_no_restart_held: assert property (p_no_restart_held) else $error("held run");

  property p_restart;
    @(posedge clk) disable iff (!reset_n)
    (state_reg == DCTI_TORQ_OFF && state_next == DCTI_RUN) |=> output_enable;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_halt_sticky;
    @(posedge clk) disable iff (!reset_n)
    (chan_a_loop_error || chan_b_loop_error) |=> $stable(chan_a_loop_error)
      && $stable(chan_b_loop_error) && !output_enable;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("loop error cleared");

  property p_response;
    @(posedge clk) disable iff (!reset_n)
    $fell(a_ok) |-> ##[0:2] !output_enable;
  endproperty
  a_response: assert property (p_response) else $error("slow inhibit");

  property p_code_torq;
    @(posedge clk) disable iff (!reset_n)
    $rose(torque_off_alarm) |-> fault_code == CODE_TORQ;
  endproperty
  a_code_torq: assert property (p_code_torq) else $error("bad code");

  c_run: cover property (@(posedge clk) disable iff (!reset_n) $rose(output_enable));
  c_torq: cover property (@(posedge clk) disable iff (!reset_n) $rose(torque_off_alarm));
  c_chan_a: cover property (@(posedge clk) disable iff (!reset_n) $rose(chan_a_loop_error));
  c_intl: cover property (@(posedge clk) disable iff (!reset_n) $rose(internal_loop_error));
endmodule : dcti_interlock

// ==== dcti_emergency_switch_model.sv ====
// Emergency switch model driving the two redundant channel contacts
`timescale 1ns/1ps
module dcti_emergency_switch_model (
  input  wire logic       clk,
  input  wire logic       press_a,
  input  wire logic       press_b,
  input  wire logic [1:0] lag_b,
  output logic            chan_a_enable_in,
  output logic            chan_b_enable_in
);
  logic [3:0] b_hist;
  logic       press_a_q;
  logic       press_b_q;
  logic [1:0] lag_q;

  // Contacts closed at time zero so the channels never float
  initial
  begin
    chan_a_enable_in = 1'b1;
    chan_b_enable_in = 1'b1;
    b_hist           = 4'hf;
    press_a_q        = 1'b0;
    press_b_q        = 1'b0;
    lag_q            = 2'h0;
  end

  // Take the falling-edge presses on the rising edge so no read races them
  always @(posedge clk)
  begin
    press_a_q <= press_a;
    press_b_q <= press_b;
    lag_q     <= lag_b;
  end

  // Contacts move off the sampling edge; channel B may trail A, as real contacts skew
  always @(negedge clk)
  begin
    chan_a_enable_in <= ~press_a_q;
    b_hist           <= {b_hist[2:0], ~press_b_q};
    chan_b_enable_in <= (lag_q == 2'h0) ? ~press_b_q : b_hist[lag_q - 2'h1];
  end
endmodule : dcti_emergency_switch_model

// ==== dcti_interlock_tb.sv ====
// Self-checking bench for the dual channel torque interlock
`timescale 1ns/1ps
module dcti_interlock_tb;
  import dcti_pkg::*;
  // Short skew window keeps single-channel runs brief
  localparam int unsigned SKEW_C = 4;
  logic       clk         = 1'b0;
  logic       reset_n     = 1'b0;
  logic       run_cmd     = 1'b0;
  logic       reset_cmd   = 1'b0;
  logic       latch_sel   = 1'b0;
  logic       restart_sel = 1'b0;
  logic       diag_fault  = 1'b0;
  logic       press_a     = 1'b0;
  logic       press_b     = 1'b0;
  logic [1:0] lag_b       = 2'h0;
  logic [2:0] hist_idx    = 3'h0;
  logic       chan_a, chan_b, oe, alarm, err_a, err_b, err_i;
  logic [7:0] code, hist;
  int         mismatches  = 0;
  int         n_checks    = 0;

  always #50 clk = ~clk;

  dcti_emergency_switch_model u_switch (.clk(clk), .press_a(press_a), .press_b(press_b),
    .lag_b(lag_b), .chan_a_enable_in(chan_a), .chan_b_enable_in(chan_b));

  dcti_interlock #(.SKEW_CYCLES(SKEW_C)) u_dut (.clk(clk), .reset_n(reset_n),
    .chan_a_enable_in(chan_a), .chan_b_enable_in(chan_b), .run_cmd(run_cmd),
    .reset_cmd(reset_cmd), .alarm_latch_select(latch_sel),
    .restart_after_reset_select(restart_sel), .diag_fault(diag_fault),
    .fault_history_index(hist_idx), .output_enable(oe), .torque_off_alarm(alarm),
    .chan_a_loop_error(err_a), .chan_b_loop_error(err_b),
    .internal_loop_error(err_i), .fault_code(code), .fault_history_entry(hist));

  task automatic results();
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  // Flags and code in one go: enable, four alarms, code
  task automatic chk_all(input logic [4:0] f, input logic [7:0] c);
    chk("flags", {3'h0, f}, {3'h0, oe, alarm, err_a, err_b, err_i});
    chk("fault_code", c, code);
  endtask : chk_all

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Bounded wait; a hang ends the run with the verdict
  task automatic wait_oe(input logic exp, input int limit);
    for (int i = 0; i < limit && oe !== exp; i++)
      cyc(1);
    chk("output_enable", {7'h0, exp}, {7'h0, oe});
    if (oe !== exp)
      results();
  endtask : wait_oe

  task automatic pulse_reset();
    reset_cmd = 1'b1;
    cyc(1);
    reset_cmd = 1'b0;
    cyc(6);
  endtask : pulse_reset

  // Power cycle: the only thing that clears loop errors
  task automatic power_up(input logic hold_a);
    reset_n = 1'b0;
    {press_a, press_b, run_cmd, reset_cmd, diag_fault, lag_b} = {hold_a, 6'h0};
    cyc(20);
    reset_n = 1'b1;
    cyc(6);
  endtask : power_up

  task automatic t_run();
    power_up(1'b1);
    run_cmd = 1'b1;
    cyc(10);
    chk_all(5'h00, CODE_NONE);
    press_a = 1'b0;
    wait_oe(1'b1, 10);
    chk_all(5'h10, CODE_NONE);
    run_cmd = 1'b0;
    wait_oe(1'b0, 4);
    run_cmd = 1'b1;
    wait_oe(1'b1, 4);
  endtask : t_run

  // Both channels drop with B trailing inside the skew window
  task automatic t_sto(input logic latch, input logic restart);
    power_up(1'b0);
    latch_sel   = latch;
    restart_sel = restart;
    run_cmd     = 1'b1;
    wait_oe(1'b1, 8);
    lag_b   = 2'h2;
    press_a = 1'b1;
    press_b = 1'b1;
    cyc(5);
    chk("output_enable", 8'h00, {7'h0, oe});
    cyc(SKEW_C + 6);
    chk_all(5'h08, CODE_TORQ);
    chk("history 0", CODE_TORQ, hist);
    hist_idx = 3'h6;
    cyc(2);
    chk("history 6", CODE_NONE, hist);
    hist_idx = 3'h0;
    {lag_b, press_a, press_b} = 4'h0;
    cyc(8);
    if (!latch)
    begin
      chk("alarm held", 8'h01, {7'h0, alarm});
      pulse_reset();
      chk("alarm cleared", 8'h00, {7'h0, alarm});
      chk("restart", {7'h0, restart}, {7'h0, oe});
    end
    else
    begin
      chk("alarm auto", 8'h00, {7'h0, alarm});
      chk("held run", 8'h00, {7'h0, oe});
      run_cmd = 1'b0;
      cyc(2);
      run_cmd = 1'b1;
      wait_oe(1'b1, 6);
    end
  endtask : t_sto

  // One channel alone drops; reset and recovery must not clear it
  task automatic t_single(input logic on_b);
    power_up(1'b0);
    latch_sel = on_b;
    run_cmd   = 1'b1;
    wait_oe(1'b1, 8);
    press_a = ~on_b;
    press_b = on_b;
    cyc(5);
    chk("output_enable", 8'h00, {7'h0, oe});
    cyc(SKEW_C + 6);
    chk_all({2'h0, ~on_b, on_b, 1'b0}, on_b ? CODE_CHANB : CODE_CHANA);
    {press_a, press_b} = 2'h0;
    cyc(6);
    pulse_reset();
    chk_all({2'h0, ~on_b, on_b, 1'b0}, on_b ? CODE_CHANB : CODE_CHANA);
  endtask : t_single

  task automatic t_diag();
    power_up(1'b0);
    run_cmd = 1'b1;
    wait_oe(1'b1, 8);
    diag_fault = 1'b1;
    cyc(3);
    diag_fault = 1'b0;
    cyc(6);
    chk_all(5'h01, CODE_INTL);
    pulse_reset();
    chk_all(5'h01, CODE_INTL);
  endtask : t_diag

  // Main sequence; loop errors first so the next power-up shows they clear
  initial
  begin
    t_single(1'b0);
    t_single(1'b1);
    t_run();
    t_sto(1'b0, 1'b0);
    t_sto(1'b0, 1'b1);
    t_sto(1'b1, 1'b0);
    t_diag();
    results();
  end
endmodule : dcti_interlock_tb
